// ==== src/scc_coprocessor.sv ====
// system control coprocessor: mode, cache locks, watchpoints, bounds.
// assumes one pipeline that presents moves, addresses and retire pulses.
`timescale 1ns/10ps
module scc_coprocessor #(
   parameter logic [7:0] IMPL_CODE = 8'h5A, // arbitrary value
   parameter logic [7:0] REV_CODE = 8'h01 // arbitrary value
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // coprocessor moves
   input scc_pkg::scc_move_t move,
   output logic [31:0] readData,
   // pipeline requests
   input scc_pkg::scc_pipe_t pipe,
   // cache refill way choice
   input wire logic iLineValidA,
   input wire logic dLineValidA,
   output logic iRefillBlockA,
   output logic dRefillBlockA,
   // mode and exception results
   output logic userMode,
   output logic fpRegs32,
   output logic [31:0] iPhysAddr,
   output logic [31:0] dPhysAddr,
   output scc_pkg::scc_exc_t exc
);
   import scc_pkg::*;

   typedef struct packed {
      logic [31:0] status;
      logic [31:0] cause;
      logic [31:0] faultAddr;
      logic [31:0] excRet;
      logic [31:0] errRet;
      logic [31:0] region_cache_algorithm;
      logic [31:0] instruction_watchpoint;
      logic [31:0] data_watchpoint;
      logic [31:0] iBase;
      logic [31:0] iBound;
      logic [31:0] dBase;
      logic [31:0] dBound;
      logic [2:0] ilCnt;
      logic [2:0] dlCnt;
      logic [2:0] iwCnt;
      logic [2:0] dwCnt;
      logic iLockOn;
      logic dLockOn;
      logic [31:0] rd;
      logic [31:0] iPa;
      logic [31:0] dPa;
      scc_exc_t exc;
   } scc_state_t;

   scc_state_t st;
   scc_state_t next_st;
   logic wr;
   logic iOut;
   logic dOut;
   logic iHit;
   logic dHit;
   logic watchOk;
   logic [31:0] cfgWord;
   logic [31:0] identWord;

   assign cfgWord = {16'h0000, 4'h0, CACHE_SIZE_8K, CACHE_SIZE_8K, 6'h00};
   assign identWord = {16'h0000, IMPL_CODE, REV_CODE};
   // doubleword moves are dropped silently, no trap
   assign wr = move.valid && move.write && !move.dword;

   always_comb begin
      next_st = st;
      iOut = 1'b0;
      dOut = 1'b0;
      iHit = 1'b0;
      dHit = 1'b0;
      next_st.exc = '0;
      // watch only when both levels clear
      watchOk = !st.status[ST_ERL] && !st.status[ST_EXL];
      // lock settles after a count of retired instructions
      if (pipe.retire && st.ilCnt != 3'h0) begin
         next_st.ilCnt = st.ilCnt - 3'h1;
      end
      if (pipe.retire && st.dlCnt != 3'h0) begin
         next_st.dlCnt = st.dlCnt - 3'h1;
      end
      // check skipped for a few instructions after enable
      if (pipe.retire && st.iwCnt != 3'h0) begin
         next_st.iwCnt = st.iwCnt - 3'h1;
      end
      if (pipe.retire && st.dwCnt != 3'h0) begin
         next_st.dwCnt = st.dwCnt - 3'h1;
      end
      next_st.iLockOn = st.status[ST_IL] && st.ilCnt == 3'h0;
      next_st.dLockOn = st.status[ST_DL] && st.dlCnt == 3'h0;
      // kernel: fixed translation, no bounds check
      if (st.status[ST_UM]) begin
         iOut = pipe.iValid && (pipe.iAddr < st.iBase ||
                                pipe.iAddr > st.iBound);
         dOut = pipe.dValid && (pipe.dAddr < st.dBase ||
                                pipe.dAddr > st.dBound);
         next_st.iPa = pipe.iAddr;
         next_st.dPa = pipe.dAddr;
      end else begin
         next_st.iPa = pipe.iAddr & KERN_MASK;
         next_st.dPa = pipe.dAddr & KERN_MASK;
      end
      iHit = pipe.iValid && st.instruction_watchpoint[WT_EN] && st.iwCnt == 3'h0 &&
             pipe.iAddr[31:2] == st.instruction_watchpoint[31:2];
      dHit = pipe.dValid && st.data_watchpoint[WT_EN] && st.dwCnt == 3'h0 &&
             pipe.dAddr[31:2] == st.data_watchpoint[31:2];
      // no miss exceptions; only these sources exist
      if (!st.status[ST_EXL] && !st.status[ST_ERL] &&
          (iOut || dOut || ((iHit || dHit) && watchOk) ||
           (pipe.intReq && st.status[ST_IE]))) begin
         next_st.exc.take = 1'b1;
         next_st.excRet = pipe.pc;
         next_st.status[ST_EXL] = 1'b1;
         next_st.cause[CA_IW] = 1'b0;
         next_st.cause[CA_DW] = 1'b0;
         next_st.exc.vector = VEC_GENERAL;
         if (iOut) begin
            next_st.exc.code = EXC_IBOUND;
            next_st.faultAddr = pipe.iAddr;
         end else if (dOut) begin
            next_st.exc.code = EXC_DBOUND;
            next_st.faultAddr = pipe.dAddr;
         end else if (iHit || dHit) begin
            // watch code and which watchpoint hit
            next_st.exc.code = EXC_WATCH;
            next_st.cause[CA_IW] = iHit;
            next_st.cause[CA_DW] = dHit && !iHit;
         end else begin
            next_st.exc.code = EXC_INT;
            next_st.exc.vector = st.cause[CA_IV] ? VEC_INTR : VEC_GENERAL;
         end
         next_st.cause[CA_CODE_LO +: 6] = next_st.exc.code;
      end else if (pipe.eret) begin
         if (st.status[ST_ERL]) begin
            next_st.status[ST_ERL] = 1'b0;
         end else begin
            next_st.status[ST_EXL] = 1'b0;
         end
      end
      // new bounds apply next cycle, well inside the allowance
      // region_cache_algorithm writes are taken as-is even for the active region
      if (wr) begin
         case (move.regNum)
            REG_STATUS: begin
               if (move.data[ST_IL] && !st.status[ST_IL]) begin
                  next_st.ilCnt = IL_SETTLE;
               end
               if (move.data[ST_DL] && !st.status[ST_DL]) begin
                  next_st.dlCnt = DL_SETTLE;
               end
               next_st.status = move.data;
            end
            // only the vector select is writable in cause
            REG_CAUSE: next_st.cause[CA_IV] = move.data[CA_IV];
            REG_EXC_RET: next_st.excRet = move.data;
            REG_ERR_RET: next_st.errRet = move.data;
            REG_REGION_CACHE_ALGORITHM: next_st.region_cache_algorithm = move.data;
            REG_INSTRUCTION_WATCHPOINT: begin
               if (move.data[WT_EN] && !st.instruction_watchpoint[WT_EN]) begin
                  next_st.iwCnt = IW_SKIP;
               end
               next_st.instruction_watchpoint = move.data;
            end
            REG_DATA_WATCHPOINT: begin
               if (move.data[WT_EN] && !st.data_watchpoint[WT_EN]) begin
                  next_st.dwCnt = DW_SKIP;
               end
               next_st.data_watchpoint = move.data;
            end
            REG_IBASE: next_st.iBase = move.data;
            REG_IBOUND: next_st.iBound = move.data;
            REG_DBASE: next_st.dBase = move.data;
            REG_DBOUND: next_st.dBound = move.data;
            // config, identity, fault address ignore writes
            default: next_st.rd = st.rd;
         endcase
      end
      // all readable registers are 32 bits
      case (move.regNum)
         REG_STATUS: next_st.rd = st.status;
         REG_CAUSE: next_st.rd = st.cause;
         REG_EXC_RET: next_st.rd = st.excRet;
         REG_ERR_RET: next_st.rd = st.errRet;
         REG_IDENT: next_st.rd = identWord;
         REG_CONFIG: next_st.rd = cfgWord;
         REG_REGION_CACHE_ALGORITHM: next_st.rd = st.region_cache_algorithm;
         REG_INSTRUCTION_WATCHPOINT: next_st.rd = st.instruction_watchpoint;
         REG_DATA_WATCHPOINT: next_st.rd = st.data_watchpoint;
         REG_FAULT: next_st.rd = st.faultAddr;
         REG_IBASE: next_st.rd = st.iBase;
         REG_IBOUND: next_st.rd = st.iBound;
         REG_DBASE: next_st.rd = st.dBase;
         REG_DBOUND: next_st.rd = st.dBound;
         default: next_st.rd = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         // locks clear, vector select clear, region_cache_algorithm reset
         st <= '0;
         st.status <= STATUS_RESET;
         st.region_cache_algorithm <= REGION_CACHE_ALGORITHM_RESET;
      end else begin
         st <= next_st;
      end
   end

   // locked set skipped unless its line is invalid
   logic iBlk;
   logic dBlk;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         iBlk <= 1'b0;
         dBlk <= 1'b0;
      end else begin
         iBlk <= next_st.iLockOn && iLineValidA;
         dBlk <= next_st.dLockOn && dLineValidA;
      end
   end

   assign readData = st.rd;
   assign iRefillBlockA = iBlk;
   assign dRefillBlockA = dBlk;
   assign userMode = st.status[ST_UM];
   assign fpRegs32 = st.status[ST_FR];
   assign iPhysAddr = st.iPa;
   assign dPhysAddr = st.dPa;
   assign exc = st.exc;

   // checks
   sequence lockWrite_s;
      wr && move.regNum == REG_STATUS && move.data[ST_IL] &&
      !st.status[ST_IL];
   endsequence

   lock_settle_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      lockWrite_s |=> st.ilCnt == IL_SETTLE)
      else $error("icache lock settle count not loaded");
   kernel_nobound_a: assert property (@(posedge ref_clk)
      disable iff (!reset_n)
      (!st.status[ST_UM] && !pipe.intReq && !(iHit || dHit))
      |=> !exc.take)
      else $error("exception in kernel mode without cause");
   ibound_code_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (iOut && !st.status[ST_EXL] && !st.status[ST_ERL]) |=>
      exc.take && exc.code == EXC_IBOUND &&
      st.faultAddr == $past(pipe.iAddr))
      else $error("instruction bound code wrong");
   watch_level_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (st.status[ST_ERL] || st.status[ST_EXL]) |=> !exc.take)
      else $error("exception taken at raised level");
   watch_code_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (exc.take && exc.code == EXC_WATCH) |->
      (st.cause[CA_IW] || st.cause[CA_DW]) &&
      exc.vector == VEC_GENERAL)
      else $error("watch exception without cause bit");
   int_vector_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (exc.take && exc.code == EXC_INT) |->
      exc.vector == ($past(st.cause[CA_IV]) ? VEC_INTR : VEC_GENERAL))
      else $error("interrupt vector wrong");
   config_ro_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (move.valid && !move.write && move.regNum == REG_CONFIG) |=>
      readData[CF_IC_LO +: 3] == CACHE_SIZE_8K &&
      readData[CF_DC_LO +: 3] == CACHE_SIZE_8K)
      else $error("config size fields wrong");
   refill_lock_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (!iLineValidA) |=> !iRefillBlockA)
      else $error("refill blocked on invalid line");
   dword_drop_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (move.valid && move.write && move.dword &&
       move.regNum == REG_REGION_CACHE_ALGORITHM) |=> $stable(st.region_cache_algorithm))
      else $error("doubleword move changed a register");
endmodule : scc_coprocessor

// ==== src/scc_pkg.sv ====
// package for the system control coprocessor: register numbers, fields,
// reset values, exception codes and vector offsets.
// assumes one core clock and a pipeline that issues moves and checks.
package scc_pkg;
   // control register numbers on the move port
   localparam logic [4:0] REG_STATUS = 5'h0C;
   localparam logic [4:0] REG_CAUSE = 5'h0D;
   localparam logic [4:0] REG_EXC_RET = 5'h0E;
   localparam logic [4:0] REG_IDENT = 5'h0F;
   localparam logic [4:0] REG_CONFIG = 5'h10;
   localparam logic [4:0] REG_REGION_CACHE_ALGORITHM = 5'h11;
   localparam logic [4:0] REG_INSTRUCTION_WATCHPOINT = 5'h12;
   localparam logic [4:0] REG_DATA_WATCHPOINT = 5'h13;
   localparam logic [4:0] REG_FAULT = 5'h08;
   localparam logic [4:0] REG_IBASE = 5'h00;
   localparam logic [4:0] REG_IBOUND = 5'h01;
   localparam logic [4:0] REG_DBASE = 5'h02;
   localparam logic [4:0] REG_DBOUND = 5'h03;
   localparam logic [4:0] REG_ERR_RET = 5'h1E;
   // status fields
   localparam int ST_IE = 0;
   localparam int ST_EXL = 1;
   localparam int ST_ERL = 2;
   localparam int ST_UM = 4;
   localparam int ST_IL = 23;
   localparam int ST_DL = 24;
   localparam int ST_FR = 26;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0004;
   // cause fields
   localparam int CA_CODE_LO = 2;
   localparam int CA_IV = 23;
   localparam int CA_IW = 24;
   localparam int CA_DW = 25;
   // watch register fields: bit 0 enables the watch exception
   localparam int WT_EN = 0;
   // config fields
   localparam logic [2:0] CACHE_SIZE_8K = 3'h1;
   localparam int CF_IC_LO = 9;
   localparam int CF_DC_LO = 6;
   localparam logic [31:0] REGION_CACHE_ALGORITHM_RESET = 32'h2223_3333;
   // exception codes
   localparam logic [5:0] EXC_INT = 6'h00;
   localparam logic [5:0] EXC_IBOUND = 6'h02;
   localparam logic [5:0] EXC_DBOUND = 6'h03;
   localparam logic [5:0] EXC_WATCH = 6'h23;
   // vector offsets
   localparam logic [11:0] VEC_GENERAL = 12'h180;
   localparam logic [11:0] VEC_INTR = 12'h200;
   // settle windows in instructions
   localparam logic [2:0] IL_SETTLE = 3'h5;
   localparam logic [2:0] DL_SETTLE = 3'h3;
   localparam logic [2:0] IW_SKIP = 3'h5;
   localparam logic [2:0] DW_SKIP = 3'h2;
   // fixed kernel translation: top three address bits cleared
   localparam logic [31:0] KERN_MASK = 32'h1FFF_FFFF;

   typedef struct packed {
      logic valid;
      logic write;
      logic dword;
      logic [4:0] regNum;
      logic [31:0] data;
   } scc_move_t;

   typedef struct packed {
      logic iValid;
      logic [31:0] iAddr;
      logic dValid;
      logic [31:0] dAddr;
      logic retire;
      logic intReq;
      logic [31:0] pc;
      logic eret;
   } scc_pipe_t;

   typedef struct packed {
      logic take;
      logic [5:0] code;
      logic [11:0] vector;
   } scc_exc_t;
endpackage : scc_pkg

// ==== bench/scc_pipe_model.sv ====
// pipeline model: issues control moves, address checks, retires, irqs.
// assumes the coprocessor samples its inputs on every rising edge.
`timescale 1ns/10ps
module scc_pipe_model (
   // clock and read answer
   input wire logic ref_clk,
   input wire logic [31:0] readData,
   // requests
   output scc_pkg::scc_move_t move,
   output scc_pkg::scc_pipe_t pipe
);
   import scc_pkg::*;
   initial begin
      move = '0;
      pipe = '0;
   end
   task automatic step();
      @(posedge ref_clk);
      #1;
   endtask : step
   task automatic retire(input int n);
      repeat (n) begin
         pipe.retire = 1'b1;
         step();
         pipe.retire = 1'b0;
         step();
      end
   endtask : retire
   task automatic wr(input logic [4:0] r, input logic [31:0] d,
         input logic dw);
      move = {1'b1, 1'b1, dw, r, d};
      step();
      // stale data inverted so a late sample cannot pass
      move = {3'h0, r, ~d};
      if (r <= REG_DBOUND) retire(5);
   endtask : wr
   task automatic rd(input logic [4:0] r, output logic [31:0] q);
      move = {3'h4, r, 32'h0};
      step();
      q = readData;
      move.valid = 1'b0;
   endtask : rd
   task automatic access(input logic isData, input logic [31:0] a);
      if (isData) begin
         pipe.dValid = 1'b1;
         pipe.dAddr = a;
      end else begin
         pipe.iValid = 1'b1;
         pipe.iAddr = a;
      end
      pipe.pc = a;
      step();
      pipe.iValid = 1'b0;
      pipe.dValid = 1'b0;
      pipe.iAddr = ~a;
      pipe.dAddr = ~a;
   endtask : access
   task automatic irq();
      pipe.intReq = 1'b1;
      step();
      pipe.intReq = 1'b0;
   endtask : irq
endmodule : scc_pipe_model

// ==== bench/system_control_coprocessor_tb.sv ====
// self-checking bench for the system control coprocessor.
// assumes the pipeline model drives every request 1 ns after an edge.
`timescale 1ns/10ps
module system_control_coprocessor_tb;
   import scc_pkg::*;
   localparam logic [7:0] IMPL = 8'h3C; // arbitrary value
   localparam logic [7:0] REV = 8'h07; // arbitrary value
   logic refClk = 1'b0;
   logic resetN = 1'b0;
   logic iLineValidA = 1'b0;
   logic dLineValidA = 1'b0;
   scc_move_t move;
   scc_pipe_t pipe;
   scc_exc_t exc;
   logic [31:0] readData, iPhysAddr, dPhysAddr;
   logic iRefillBlockA, dRefillBlockA, userMode, fpRegs32;
   int errCount = 0;
   int comparisons = 0;
   int cycles = 0;

   always #10 refClk = ~refClk;

   scc_coprocessor #(.IMPL_CODE(IMPL), .REV_CODE(REV)) u_dut (
      .ref_clk(refClk), .reset_n(resetN), .move(move),
      .readData(readData), .pipe(pipe), .iLineValidA(iLineValidA),
      .dLineValidA(dLineValidA), .iRefillBlockA(iRefillBlockA),
      .dRefillBlockA(dRefillBlockA), .userMode(userMode),
      .fpRegs32(fpRegs32), .iPhysAddr(iPhysAddr),
      .dPhysAddr(dPhysAddr), .exc(exc));
   scc_pipe_model u_pipe (
      .ref_clk(refClk), .readData(readData), .move(move), .pipe(pipe));

   task automatic check(input string what, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         errCount++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic expect_exc(input logic [5:0] c, input logic [11:0] v);
      check("take", exc.take, 1'b1);
      check("code", exc.code, c);
      check("vector", exc.vector, v);
   endtask : expect_exc
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, errCount);
      if (errCount == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic test_reset();
      logic [31:0] q;
      u_pipe.rd(REG_REGION_CACHE_ALGORITHM, q);
      check("region_cache_algorithm", q, REGION_CACHE_ALGORITHM_RESET);
      u_pipe.rd(REG_STATUS, q);
      check("status", q, STATUS_RESET);
      u_pipe.rd(REG_CAUSE, q);
      check("cause iv", q[CA_IV], 1'b0);
      check("iblock", iRefillBlockA, 1'b0);
      $display("test reset done");
   endtask : test_reset
   task automatic test_readonly();
      logic [31:0] q;
      u_pipe.wr(REG_CONFIG, 32'hFFFF_FFFF, 1'b0);
      u_pipe.rd(REG_CONFIG, q);
      check("config ic", q[CF_IC_LO +: 3], CACHE_SIZE_8K);
      check("config dc", q[CF_DC_LO +: 3], CACHE_SIZE_8K);
      u_pipe.wr(REG_IDENT, 32'h0, 1'b0);
      u_pipe.rd(REG_IDENT, q);
      check("ident", q[15:0], {IMPL, REV});
      u_pipe.wr(REG_REGION_CACHE_ALGORITHM, 32'h1234_5678, 1'b1);
      u_pipe.rd(REG_REGION_CACHE_ALGORITHM, q);
      check("region_cache_algorithm dword", q, REGION_CACHE_ALGORITHM_RESET);
      u_pipe.wr(REG_REGION_CACHE_ALGORITHM, 32'h1234_5678, 1'b0);
      u_pipe.rd(REG_REGION_CACHE_ALGORITHM, q);
      check("region_cache_algorithm rw", q, 32'h1234_5678);
      $display("test readonly done");
   endtask : test_readonly
   task automatic test_mode();
      u_pipe.wr(REG_STATUS, (32'h1 << ST_UM) | (32'h1 << ST_FR), 1'b0);
      u_pipe.step();
      check("user", userMode, 1'b1);
      check("fp32", fpRegs32, 1'b1);
      u_pipe.wr(REG_STATUS, 32'h0, 1'b0);
      u_pipe.step();
      check("kernel", userMode, 1'b0);
      check("fp16", fpRegs32, 1'b0);
      $display("test mode done");
   endtask : test_mode
   task automatic test_lock();
      iLineValidA = 1'b1;
      dLineValidA = 1'b1;
      u_pipe.wr(REG_STATUS, 32'h1 << ST_IL, 1'b0);
      u_pipe.retire(5);
      check("iblock", iRefillBlockA, 1'b1);
      check("dfree", dRefillBlockA, 1'b0);
      iLineValidA = 1'b0;
      u_pipe.step();
      check("iinvalid", iRefillBlockA, 1'b0);
      iLineValidA = 1'b1;
      u_pipe.wr(REG_STATUS, 32'h1 << ST_DL, 1'b0);
      u_pipe.retire(3);
      check("dblock", dRefillBlockA, 1'b1);
      check("ifree", iRefillBlockA, 1'b0);
      dLineValidA = 1'b0;
      u_pipe.step();
      check("dinvalid", dRefillBlockA, 1'b0);
      u_pipe.wr(REG_STATUS, 32'h0, 1'b0);
      $display("test lock done");
   endtask : test_lock
   task automatic test_bounds();
      u_pipe.wr(REG_IBASE, 32'h0000_1000, 1'b0);
      u_pipe.wr(REG_IBOUND, 32'h0000_1FFF, 1'b0);
      u_pipe.wr(REG_DBASE, 32'h0000_4000, 1'b0);
      u_pipe.wr(REG_DBOUND, 32'h0000_4FFF, 1'b0);
      u_pipe.wr(REG_STATUS, 32'h1 << ST_UM, 1'b0);
      u_pipe.access(1'b0, 32'h0000_1FFF);
      check("in bound", exc.take, 1'b0);
      u_pipe.access(1'b0, 32'h0000_2000);
      expect_exc(EXC_IBOUND, VEC_GENERAL);
      u_pipe.wr(REG_STATUS, 32'h1 << ST_UM, 1'b0);
      u_pipe.access(1'b1, 32'h0000_3FFF);
      expect_exc(EXC_DBOUND, VEC_GENERAL);
      u_pipe.wr(REG_STATUS, 32'h0, 1'b0);
      u_pipe.access(1'b0, 32'hE000_2000);
      check("kern take", exc.take, 1'b0);
      check("kern phys", iPhysAddr, 32'h0000_2000);
      u_pipe.access(1'b1, 32'hA000_4000);
      check("kern dtake", exc.take, 1'b0);
      check("kern dphys", dPhysAddr, 32'h0000_4000);
      $display("test bounds done");
   endtask : test_bounds
   task automatic test_intr();
      logic [31:0] q;
      u_pipe.wr(REG_STATUS, 32'h1 << ST_IE, 1'b0);
      u_pipe.irq();
      expect_exc(EXC_INT, VEC_GENERAL);
      u_pipe.wr(REG_CAUSE, 32'h1 << CA_IV, 1'b0);
      u_pipe.rd(REG_CAUSE, q);
      check("cause iv", q[CA_IV], 1'b1);
      u_pipe.wr(REG_STATUS, 32'h1 << ST_IE, 1'b0);
      u_pipe.irq();
      expect_exc(EXC_INT, VEC_INTR);
      u_pipe.wr(REG_STATUS, 32'h0, 1'b0);
      $display("test intr done");
   endtask : test_intr
   task automatic test_watch();
      logic [31:0] q;
      u_pipe.wr(REG_INSTRUCTION_WATCHPOINT, 32'h0000_0101, 1'b0);
      u_pipe.retire(5);
      u_pipe.access(1'b0, 32'h0000_0100);
      expect_exc(EXC_WATCH, VEC_GENERAL);
      u_pipe.rd(REG_CAUSE, q);
      check("iw", q[CA_IW], 1'b1);
      check("dw", q[CA_DW], 1'b0);
      u_pipe.access(1'b0, 32'h0000_0100);
      check("exl hold", exc.take, 1'b0);
      u_pipe.wr(REG_INSTRUCTION_WATCHPOINT, 32'h0, 1'b0);
      u_pipe.wr(REG_STATUS, 32'h0, 1'b0);
      u_pipe.wr(REG_DATA_WATCHPOINT, 32'h0000_0201, 1'b0);
      u_pipe.retire(2);
      u_pipe.access(1'b1, 32'h0000_0200);
      expect_exc(EXC_WATCH, VEC_GENERAL);
      u_pipe.rd(REG_CAUSE, q);
      check("dw", q[CA_DW], 1'b1);
      $display("test watch done");
   endtask : test_watch

   // ceiling far above the 123 cycles the tests need
   always @(posedge refClk) begin
      cycles++;
      if (cycles == 4000) begin
         errCount++;
         end_of_test();
      end
   end

   initial begin
      repeat (5) @(posedge refClk);
      #1;
      resetN = 1'b1;
      test_reset();
      test_readonly();
      test_mode();
      test_lock();
      test_bounds();
      test_intr();
      test_watch();
      end_of_test();
   end
endmodule : system_control_coprocessor_tb
